// ---- src/bvm_pkg.sv ----
// package for the battery voltage monitor: register map, resets, modes
`default_nettype none
package bvm_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 8;
  localparam int          RES_W           = 10;
  localparam logic [6:0]  ADDR_SRC_SEL    = 7'h11;
  localparam logic [6:0]  ADDR_UNDER_THR  = 7'h12;
  localparam logic [6:0]  ADDR_OVER_THR   = 7'h13;
  localparam logic [6:0]  ADDR_HYST       = 7'h14;
  localparam logic [6:0]  ADDR_BAT_HIGH   = 7'h15;
  localparam logic [6:0]  ADDR_BAT_LOW    = 7'h16;
  localparam logic [6:0]  ADDR_SNS_HIGH   = 7'h17;
  localparam logic [6:0]  ADDR_SNS_LOW    = 7'h18;
  localparam logic [6:0]  ADDR_EVENT      = 7'h19;
  localparam logic [6:0]  ADDR_SUPPLY_ST  = 7'h1b;
  localparam logic [7:0]  RST_SRC_SEL     = 8'h00;
  localparam logic [7:0]  RST_UNDER_THR   = 8'h00;
  localparam logic [7:0]  RST_OVER_THR    = 8'hff;
  localparam logic [7:0]  RST_HYST        = 8'h00;
  localparam int          SRC_SEL_BIT     = 0;
  localparam int          MSB_FLAG_BIT    = 2;
  localparam int          OVER_STEP_HI    = 7;
  localparam int          OVER_STEP_LO    = 4;
  localparam int          UNDER_STEP_HI   = 3;
  localparam int          UNDER_STEP_LO   = 0;
  localparam int          EV_POWER_UP_BIT = 2;
  localparam int          EV_OVER_BIT     = 1;
  localparam int          EV_UNDER_BIT    = 0;
  localparam int          ST_OVER_BIT     = 5;
  localparam int          ST_UNDER_BIT    = 4;
  // one hysteresis step is 1/255 of full scale, i.e. 4 result lsbs at 10 bits
  localparam int          STEP_SHIFT      = 2;
  typedef enum logic [1:0] {
    BVM_OFF     = 2'b00,
    BVM_STANDBY = 2'b01,
    BVM_NORMAL  = 2'b10
  } bvm_mode_type;
endpackage
`default_nettype wire

// ---- src/bvm_level_detect.sv ----
// threshold comparator with hysteresis and one-shot event for one direction
`default_nettype none
module bvm_level_detect
  import bvm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic             is_over,
  input  wire logic [RES_W-1:0] sample,
  input  wire logic             sample_vld,
  input  wire logic [7:0]       code,
  input  wire logic [3:0]       step,
  output logic                  level,
  output logic                  event_pulse
);
  // code is the upper eight bits of a 10-bit trip value [RL19]
  wire logic [RES_W-1:0] trip     = {code, 2'b00};
  wire logic [RES_W+1:0] hyst     = {6'h00, step, 2'b00};
  wire logic [RES_W+1:0] trip_ext = {2'b00, trip};
  wire logic [RES_W+1:0] samp_ext = {2'b00, sample};
  // overvoltage: above trip sets, below trip minus hysteresis releases [RL9] [RL11] [RL12]
  wire logic over_set = samp_ext > trip_ext;
  wire logic over_rel = samp_ext + hyst < trip_ext;
  // undervoltage: code zero disables detection entirely [RL8] [RL10] [RL13]
  wire logic under_set = (code != 8'h00) && (samp_ext < trip_ext);
  wire logic under_rel = (code == 8'h00) || (samp_ext > trip_ext + hyst);
  wire logic set_c = is_over ? over_set : under_set;
  wire logic rel_c = is_over ? over_rel : under_rel;
  logic level_q;
  logic level_d;
  // level is held low outside Normal mode and in Normal only changes on fresh samples; a new event needs a release first
  assign level_d = !enable ? 1'b0 :
                   !sample_vld ? level_q :
                   (!level_q && set_c) ? 1'b1 :
                   (level_q && rel_c) ? 1'b0 : level_q; // [RL4] [RL20]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end
  assign level       = level_q; // [RL14]
  assign event_pulse = level_d && !level_q;
endmodule
`default_nettype wire

// ---- src/bvm_top.sv ----
// battery voltage monitor: supply mode sequencing, result registers, events
// Operation
// RL1: both supplies below power-off level enters Off
// RL2: leaving Off for Standby sets power-up flag
// RL3: two 10-bit channels, battery and sense
// RL4: monitor active only in Normal mode
// RL5: under/over condition sets matching event flag
// RL6: source_select bit 0 picks battery or sense
// RL7: host writes zero to bits 7:1
// RL8: under trip equals code/255 of 20 V
// RL9: over trip equals code/255 of 20 V
// RL10: under code zero disables undervoltage detection
// RL11: over code FF trips above 3FC
// RL12: over releases below trip minus step
// RL13: under releases above trip plus step
// RL14: live level bits apart from event flags
// RL15: battery result split high byte, low bits
// RL16: battery low bit 2 shows high read
// RL17: sense result stored the same way
// RL18: under level reads 1 below threshold
// RL19: codes compare as upper bits of ten
// RL20: no repeat event before hysteresis release
`default_nettype none
module bvm_top
  import bvm_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              BAT_BELOW_POFF,
  input  wire logic              CONV_BELOW_POFF,
  input  wire logic              BAT_ABOVE_PON,
  input  wire logic              NORMAL_REQ,
  input  wire logic [RES_W-1:0]  BAT_SAMPLE,
  input  wire logic [RES_W-1:0]  SENSE_SAMPLE,
  input  wire logic              SAMPLE_VALID,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  output logic                   SUPPLY_ON,
  output logic                   MONITOR_ACTIVE,
  output logic                   LOAD_SHED
);
  ////////////////////////////////////////////////////////////////////////////
  // supply mode sequencing
  bvm_mode_type mode_q;
  bvm_mode_type mode_d;
  wire logic power_fail = BAT_BELOW_POFF && CONV_BELOW_POFF;
  // power fail wins over everything, immediately [RL1]
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      BVM_OFF: begin
        if (!power_fail && BAT_ABOVE_PON) mode_d = BVM_STANDBY;
      end
      BVM_STANDBY: begin
        if (power_fail) mode_d = BVM_OFF; // [RL1]
        else if (NORMAL_REQ) mode_d = BVM_NORMAL;
      end
      BVM_NORMAL: begin
        if (power_fail) mode_d = BVM_OFF; // [RL1]
        else if (!NORMAL_REQ) mode_d = BVM_STANDBY;
      end
      default: mode_d = BVM_OFF;
    endcase
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_q <= BVM_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end
  wire logic in_normal  = (mode_q == BVM_NORMAL);
  wire logic in_off     = (mode_q == BVM_OFF);
  wire logic off_leave  = in_off && (mode_d == BVM_STANDBY);
  wire logic off_enter  = !in_off && (mode_d == BVM_OFF);
  assign SUPPLY_ON      = !in_off;
  assign MONITOR_ACTIVE = in_normal; // [RL4]

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode
  wire logic acc_ok   = !in_off;
  wire logic wr_src   = acc_ok && REG_WR && (REG_ADDR == ADDR_SRC_SEL);
  wire logic wr_uthr  = acc_ok && REG_WR && (REG_ADDR == ADDR_UNDER_THR);
  wire logic wr_othr  = acc_ok && REG_WR && (REG_ADDR == ADDR_OVER_THR);
  wire logic wr_hyst  = acc_ok && REG_WR && (REG_ADDR == ADDR_HYST);
  wire logic wr_event = acc_ok && REG_WR && (REG_ADDR == ADDR_EVENT);
  wire logic rd_bhi   = acc_ok && REG_RD && (REG_ADDR == ADDR_BAT_HIGH);
  wire logic rd_shi   = acc_ok && REG_RD && (REG_ADDR == ADDR_SNS_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // control registers; all return to defaults when the device drops to Off
  logic [7:0] src_q;
  logic [7:0] uthr_q;
  logic [7:0] othr_q;
  logic [7:0] hyst_q;
  // bits 7:1 are stored as written; host keeps them zero [RL7]
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      src_q  <= RST_SRC_SEL;
      uthr_q <= RST_UNDER_THR;
      othr_q <= RST_OVER_THR;
      hyst_q <= RST_HYST;
    end else if (off_enter) begin
      src_q  <= RST_SRC_SEL;
      uthr_q <= RST_UNDER_THR;
      othr_q <= RST_OVER_THR;
      hyst_q <= RST_HYST;
    end else begin
      if (wr_src)  src_q  <= REG_WDATA;
      if (wr_uthr) uthr_q <= REG_WDATA;
      if (wr_othr) othr_q <= REG_WDATA;
      if (wr_hyst) hyst_q <= REG_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion results, captured only in Normal mode [RL3] [RL4]
  logic [RES_W-1:0] bat_q;
  logic [RES_W-1:0] sns_q;
  logic             bat_msb_read_q;
  logic             sns_msb_read_q;
  wire logic        take = in_normal && SAMPLE_VALID;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bat_q <= '0;
      sns_q <= '0;
    end else if (mode_q == BVM_STANDBY) begin
      bat_q <= '0;
      sns_q <= '0;
    end else if (take) begin
      bat_q <= BAT_SAMPLE;
      sns_q <= SENSE_SAMPLE;
    end
  end
  // msb-read flag: set by reading the high byte, cleared by a new result;
  // the read wins if both land together so the host never misses it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bat_msb_read_q <= 1'b0;
      sns_msb_read_q <= 1'b0;
    end else if (off_enter) begin
      bat_msb_read_q <= 1'b0;
      sns_msb_read_q <= 1'b0;
    end else begin
      if (rd_bhi) bat_msb_read_q <= 1'b1; // [RL16]
      else if (take) bat_msb_read_q <= 1'b0;
      if (rd_shi) sns_msb_read_q <= 1'b1; // [RL17]
      else if (take) sns_msb_read_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel selection and level detection
  wire logic [RES_W-1:0] sel_sample = src_q[SRC_SEL_BIT] ? SENSE_SAMPLE : BAT_SAMPLE; // [RL6]
  wire logic under_level;
  wire logic over_level;
  wire logic under_ev;
  wire logic over_ev;
  bvm_level_detect u_under (
    .clk         (CLK),
    .rst         (RST),
    .enable      (in_normal),
    .is_over     (1'b0),
    .sample      (sel_sample),
    .sample_vld  (SAMPLE_VALID),
    .code        (uthr_q),
    .step        (hyst_q[UNDER_STEP_HI:UNDER_STEP_LO]),
    .level       (under_level),
    .event_pulse (under_ev)
  );
  bvm_level_detect u_over (
    .clk         (CLK),
    .rst         (RST),
    .enable      (in_normal),
    .is_over     (1'b1),
    .sample      (sel_sample),
    .sample_vld  (SAMPLE_VALID),
    .code        (othr_q),
    .step        (hyst_q[OVER_STEP_HI:OVER_STEP_LO]),
    .level       (over_level),
    .event_pulse (over_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky event flags, write one to clear; a new event beats the clear
  logic under_flag_q;
  logic over_flag_q;
  logic pwr_flag_q;
  wire logic clr_u = wr_event && REG_WDATA[EV_UNDER_BIT];
  wire logic clr_o = wr_event && REG_WDATA[EV_OVER_BIT];
  wire logic clr_p = wr_event && REG_WDATA[EV_POWER_UP_BIT];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      under_flag_q <= 1'b0;
      over_flag_q  <= 1'b0;
      pwr_flag_q   <= 1'b0;
    end else begin
      under_flag_q <= in_off ? 1'b0 : (under_ev | (under_flag_q & ~clr_u)); // [RL5]
      over_flag_q  <= in_off ? 1'b0 : (over_ev | (over_flag_q & ~clr_o)); // [RL5]
      pwr_flag_q   <= off_leave | (pwr_flag_q & ~clr_p & ~in_off); // [RL2]
    end
  end
  // optional load shedding follows the latched under and over events
  assign LOAD_SHED = under_flag_q | over_flag_q; // [RL5]

  ////////////////////////////////////////////////////////////////////////////
  // read data; Off mode and unmapped addresses read zero
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  wire logic [7:0] bat_low = {5'h00, bat_msb_read_q, bat_q[1:0]}; // [RL15] [RL16]
  wire logic [7:0] sns_low = {5'h00, sns_msb_read_q, sns_q[1:0]}; // [RL17]
  wire logic [7:0] ev_rd   = {5'h00, pwr_flag_q, over_flag_q, under_flag_q};
  wire logic [7:0] st_rd   = {2'b00, over_level, under_level, 4'h0}; // [RL14] [RL18]
  always_comb begin
    rdata_d = '0;
    if (acc_ok) begin
      unique case (REG_ADDR)
        ADDR_SRC_SEL:   rdata_d = src_q;
        ADDR_UNDER_THR: rdata_d = uthr_q;
        ADDR_OVER_THR:  rdata_d = othr_q;
        ADDR_HYST:      rdata_d = hyst_q;
        ADDR_BAT_HIGH:  rdata_d = bat_q[RES_W-1:2]; // [RL15]
        ADDR_BAT_LOW:   rdata_d = bat_low;
        ADDR_SNS_HIGH:  rdata_d = sns_q[RES_W-1:2]; // [RL17]
        ADDR_SNS_LOW:   rdata_d = sns_low;
        ADDR_EVENT:     rdata_d = ev_rd;
        ADDR_SUPPLY_ST: rdata_d = st_rd;
        default:        rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= '0;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end
  end
  assign REG_RDATA = rdata_q;
endmodule
`default_nettype wire

// ---- bench/bvm_checker.sv ----
// assertions on the battery voltage monitor top ports
`default_nettype none
module bvm_checker
  import bvm_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              BAT_BELOW_POFF,
  input wire logic              CONV_BELOW_POFF,
  input wire logic              BAT_ABOVE_PON,
  input wire logic              NORMAL_REQ,
  input wire logic [RES_W-1:0]  BAT_SAMPLE,
  input wire logic [RES_W-1:0]  SENSE_SAMPLE,
  input wire logic              SAMPLE_VALID,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              SUPPLY_ON,
  input wire logic              MONITOR_ACTIVE,
  input wire logic              LOAD_SHED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  localparam logic [16:0] CFG_RST = {1'b0, RST_UNDER_THR, RST_OVER_THR};
  logic      [16:0]      cfg_q;
  logic      [RES_W-1:0] last_q;
  wire logic [RES_W:0]   smp  = {1'b0, cfg_q[16] ? SENSE_SAMPLE : BAT_SAMPLE};
  wire logic [RES_W:0]   last = {1'b0, last_q};
  wire logic [RES_W:0]   t_un = {1'b0, cfg_q[15:8], 2'b00};
  wire logic [RES_W:0]   t_ov = {1'b0, cfg_q[7:0], 2'b00};
  wire logic             wok  = REG_WR && SUPPLY_ON;
  wire logic             ev   = MONITOR_ACTIVE && SAMPLE_VALID;
  wire logic             both = BAT_BELOW_POFF && CONV_BELOW_POFF;
  // shadow of select and thresholds; off mode restores defaults
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      cfg_q <= CFG_RST;
    else if (!SUPPLY_ON)
      cfg_q <= CFG_RST;
    else if (wok && REG_ADDR == ADDR_SRC_SEL)
      cfg_q[16] <= REG_WDATA[SRC_SEL_BIT];
    else if (wok && REG_ADDR == ADDR_UNDER_THR)
      cfg_q[15:8] <= REG_WDATA;
    else if (wok && REG_ADDR == ADDR_OVER_THR)
      cfg_q[7:0] <= REG_WDATA;
  end
  // previous sample; far from a trip it proves the level was released
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      last_q <= '0;
    else if (!MONITOR_ACTIVE)
      last_q <= '0;
    else if (SAMPLE_VALID)
      last_q <= smp[RES_W-1:0];
  end
  ////////////////////////////////////////
  off_entry_a:
    assert property (both |=> !SUPPLY_ON && !MONITOR_ACTIVE) else $error("off not entered");
  power_on_a:
    assert property (!SUPPLY_ON && BAT_ABOVE_PON && !both |=> SUPPLY_ON) else $error("no wake");
  active_on_a:
    assert property (MONITOR_ACTIVE |-> SUPPLY_ON) else $error("monitor active while off");
  enter_norm_a:
    assert property (SUPPLY_ON && NORMAL_REQ && !both |=> MONITOR_ACTIVE) else $error("no normal");
  leave_norm_a:
    assert property (!NORMAL_REQ |=> !MONITOR_ACTIVE) else $error("monitor left active");
  over_set_a:
    assert property (ev && smp > t_ov && last + 11'h03c < t_ov |-> ##[1:2] LOAD_SHED)
      else $error("over event missed");
  under_set_a:
    assert property (ev && cfg_q[15:8] != 8'h00 && smp < t_un && last > t_un + 11'h03c
      |-> ##[1:2] LOAD_SHED) else $error("under event missed");
  quiet_a:
    assert property (ev && !LOAD_SHED && !$past(LOAD_SHED) && smp <= t_ov
      && (cfg_q[15:8] == 8'h00 || smp >= t_un) |=> !LOAD_SHED) else $error("false event");
  cover property (ev);
  cover property ($rose(LOAD_SHED));
  cover property ($fell(SUPPLY_ON));
endmodule
bind bvm_top bvm_checker bvm_checker_inst (.CLK, .RST, .BAT_BELOW_POFF, .CONV_BELOW_POFF,
  .BAT_ABOVE_PON, .NORMAL_REQ, .BAT_SAMPLE, .SENSE_SAMPLE, .SAMPLE_VALID, .REG_ADDR,
  .REG_WDATA, .REG_WR, .SUPPLY_ON, .MONITOR_ACTIVE, .LOAD_SHED);
`default_nettype wire

// ---- bench/bvm_host_model.sv ----
// host model: register reads and writes over the strobe port
`default_nettype none
module bvm_host_model
  import bvm_pkg::*;
(
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // one access; the strobe stands one cycle, the edge after launch takes it
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= (a == ADDR_SRC_SEL) ? (d & 8'h01) : d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines show a changed pattern, never the stale value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- bench/bvm_top_tb_top.sv ----
// self-checking bench for the battery voltage monitor
`default_nettype none
module bvm_top_tb_top
  import bvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   blo = 1'b0;
  logic                   clo = 1'b0;
  logic                   pon = 1'b0;
  logic                   norm = 1'b0;
  logic                   vld = 1'b0;
  logic                   rd_seen = 1'b0;
  logic      [RES_W-1:0]  bat = '0;
  logic      [RES_W-1:0]  sns = '0;
  logic      [RES_W-1:0]  b;
  logic      [RES_W-1:0]  s;
  logic      [15:0]       exp_q[$];
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] wdat;
  wire logic [DATA_W-1:0] rdat;
  wire logic              wr_s, rd_s, sup, act, shed;
  int                     mismatches = 0;
  int                     n_tests = 0;
  bvm_top bvm_top_inst (.CLK(clk), .RST(rst), .BAT_BELOW_POFF(blo), .CONV_BELOW_POFF(clo),
    .BAT_ABOVE_PON(pon), .NORMAL_REQ(norm), .BAT_SAMPLE(bat), .SENSE_SAMPLE(sns),
    .SAMPLE_VALID(vld), .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdat), .SUPPLY_ON(sup), .MONITOR_ACTIVE(act), .LOAD_SHED(shed));
  bvm_host_model bvm_host_model_inst (.clk(clk), .reg_addr(addr), .reg_wdata(wdat),
    .reg_wr(wr_s), .reg_rd(rd_s));
  always #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] e);
    n_tests++;
    if (seen !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, seen);
    end
  endtask
  // the note goes in first so the watcher finds it when the data lands
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e & m});
    bvm_host_model_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bvm_host_model_inst.access(1'b1, a, d);
  endtask
  task automatic smp(input logic [RES_W-1:0] bv, input logic [RES_W-1:0] sv);
    @(posedge clk);
    bat <= bv;
    sns <= sv;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
  endtask
  task automatic power(input logic lo, input logic on);
    @(posedge clk);
    blo <= lo;
    clo <= lo;
    pon <= on;
    repeat (2) @(posedge clk);
    #1 check("supply_on", {7'h00, sup}, {7'h00, on});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // read data lands on the taking edge and is checked one edge later
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() != 0)
      check("rdata", rdat & exp_q[0][15:8], exp_q[0][7:0]);
    if (rd_seen && exp_q.size() != 0)
      void'(exp_q.pop_front());
    rd_seen <= rd_s & sup;
  end
  // watchdog well beyond the under two hundred cycles the tests need
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    void'($urandom(8));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    power(1'b0, 1'b1);
    rd(ADDR_SRC_SEL, RST_SRC_SEL, 8'h01);
    rd(ADDR_UNDER_THR, RST_UNDER_THR, 8'hff);
    rd(ADDR_OVER_THR, RST_OVER_THR, 8'hff);
    rd(ADDR_HYST, RST_HYST, 8'hff);
    rd(ADDR_EVENT, 8'h04, 8'h07);
    wr(ADDR_EVENT, 8'h07);
    $display("test power_up done");
    norm <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      b = RES_W'($urandom);
      s = RES_W'($urandom);
      smp(b, s);
      rd(ADDR_BAT_LOW, {6'h00, b[1:0]}, 8'h07);
      rd(ADDR_BAT_HIGH, b[9:2], 8'hff);
      rd(ADDR_BAT_LOW, {6'h01, b[1:0]}, 8'h07);
      rd(ADDR_SNS_LOW, {6'h00, s[1:0]}, 8'h07);
      rd(ADDR_SNS_HIGH, s[9:2], 8'hff);
      rd(ADDR_SNS_LOW, {6'h01, s[1:0]}, 8'h07);
    end
    $display("test results done");
    wr(ADDR_EVENT, 8'h07);
    smp(10'h3fc, 10'h000);
    rd(ADDR_EVENT, 8'h00, 8'h03);
    smp(10'h000, 10'h000);
    smp(10'h3fd, 10'h000);
    rd(ADDR_EVENT, 8'h02, 8'h03);
    rd(ADDR_SUPPLY_ST, 8'h20, 8'h30);
    wr(ADDR_OVER_THR, 8'h80);
    wr(ADDR_HYST, 8'h20);
    wr(ADDR_EVENT, 8'h07);
    smp(10'h1f9, 10'h000);
    rd(ADDR_SUPPLY_ST, 8'h20, 8'h30);
    smp(10'h201, 10'h000);
    rd(ADDR_EVENT, 8'h00, 8'h03);
    smp(10'h1f7, 10'h000);
    rd(ADDR_SUPPLY_ST, 8'h00, 8'h30);
    smp(10'h201, 10'h000);
    rd(ADDR_EVENT, 8'h02, 8'h03);
    $display("test over done");
    wr(ADDR_OVER_THR, 8'hff);
    wr(ADDR_HYST, 8'h01);
    wr(ADDR_EVENT, 8'h07);
    smp(10'h000, 10'h000);
    rd(ADDR_EVENT, 8'h00, 8'h03);
    smp(10'h200, 10'h000);
    wr(ADDR_UNDER_THR, 8'h40);
    smp(10'h0ff, 10'h3ff);
    rd(ADDR_EVENT, 8'h01, 8'h03);
    rd(ADDR_SUPPLY_ST, 8'h10, 8'h30);
    smp(10'h104, 10'h000);
    rd(ADDR_SUPPLY_ST, 8'h10, 8'h30);
    smp(10'h105, 10'h000);
    rd(ADDR_SUPPLY_ST, 8'h00, 8'h30);
    wr(ADDR_SRC_SEL, 8'hff);
    wr(ADDR_EVENT, 8'h07);
    smp(10'h200, 10'h0ff);
    rd(ADDR_EVENT, 8'h01, 8'h03);
    rd(ADDR_SRC_SEL, 8'h01, 8'h01);
    $display("test under done");
    norm <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("monitor_active", {7'h00, act}, 8'h00);
    rd(ADDR_BAT_HIGH, 8'h00, 8'hff);
    wr(ADDR_EVENT, 8'h07);
    smp(10'h000, 10'h000);
    rd(ADDR_EVENT, 8'h00, 8'h03);
    power(1'b1, 1'b0);
    power(1'b0, 1'b1);
    rd(ADDR_OVER_THR, 8'hff, 8'hff);
    rd(ADDR_EVENT, 8'h04, 8'h07);
    repeat (3) @(posedge clk);
    $display("test modes done");
    report_and_stop();
  end
endmodule
`default_nettype wire
